// ===== shared/standby_pkg.sv
// Constants, types and decode helpers for the standby controller.
// Assumes one 200 MHz core clock and a byte-wide register port.
//
// Overview of operation
// - Crystal-clocked core waits settling after stop exit.
// - Reset loads wait-select with longest wait code.
// - Code in bits 2:0, codes 1-5, upper zero.
// - Counter stops at selected wait; longer bits stay clear.
// - Settling counted only once crystal oscillation begins.
// - Halt enters from any processor clock source.
// - Halt gates off the core clock.
// - Halt on a main clock keeps fast oscillator and core's source.
// - Halt retains memory, latches, other oscillator states.
// - Unused external clocks follow their applied signal.
// - Status bits set shortest first, then stay set.
// - Status cleared on reset, stop, crystal stop control.
package standby_pkg;

   // ----------------------------------------------------------------
   // Register map and layout
   // ----------------------------------------------------------------
   localparam logic [15:0] ADDR_WAIT_SEL = 16'hffa4; // Wait select
   localparam logic [15:0] ADDR_SETTLE_STAT = 16'hffa3; // Status
   localparam int WAIT_CODE_W = 3; // Code field, bits 2:0
   localparam logic [2:0] WAIT_SEL_RESET = 3'h5; // Longest wait
   localparam int NUM_THRESH = 5; // Settling thresholds
   localparam logic [NUM_THRESH-1:0] STAT_RESET = 5'h00; // Cleared
   localparam int STAT_FIRST_BIT = 4; // Shortest threshold bit
   localparam int CNT_W = 17; // Holds two to the sixteenth
   // Threshold exponents in crystal periods, shortest first
   localparam int SETTLE_EXP [NUM_THRESH] = '{11, 13, 14, 15, 16};

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_STOP, ST_WAIT}
      pwr_state_e;
   typedef enum logic [1:0]
      {SRC_FAST_INT, SRC_CRYSTAL, SRC_EXT_MAIN, SRC_SUBSYS} clk_src_e;
   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } reg_req_s;
   typedef struct packed
   {
      logic fast_int;
      logic crystal;
      logic subsys;
      logic slow_int;
   } osc_run_s;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   // Period count of a wait code; prohibited codes act as longest
   function automatic logic [CNT_W-1:0] wait_limit(input logic [2:0] c);
      logic [CNT_W-1:0] lim;
      lim = CNT_W'(1) << SETTLE_EXP[NUM_THRESH-1];
      for (int k = 0; k < NUM_THRESH; k++)
      begin
         if (int'(c) == k + 1)
            lim = CNT_W'(1) << SETTLE_EXP[k];
      end
      return lim;
   endfunction

   // Status pattern reached by a count, capped at the selected wait
   function automatic logic [NUM_THRESH-1:0] stat_of
      (input logic [CNT_W-1:0] cnt, input logic [2:0] c);
      logic [NUM_THRESH-1:0] s;
      logic [CNT_W-1:0] th;
      s = '0;
      for (int k = 0; k < NUM_THRESH; k++)
      begin
         th = CNT_W'(1) << SETTLE_EXP[k];
         if (cnt >= th && th <= wait_limit(c))
            s[STAT_FIRST_BIT-k] = 1'b1;
      end
      return s;
   endfunction

endpackage

// ===== src/settle_counter.sv
// Crystal settling counter, saturating at a programmable limit.
// Assumes step is a one-cycle pulse per crystal period.
`timescale 1ns/1ps

module settle_counter
   import standby_pkg::*;
#(
   parameter int W = CNT_W
)
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic clear,
   input wire logic step,
   input wire logic [W-1:0] limit,
   output logic [W-1:0] count
);

   logic [W-1:0] count_r; // Periods counted so far
   logic [W-1:0] count_nxt; // Next count

   // ----------------------------------------------------------------
   // Count logic
   // ----------------------------------------------------------------
   // Saturation keeps longer thresholds unreachable
   always_comb
   begin
      count_nxt = count_r;
      if (clear)
         count_nxt = '0; // Restart from zero
      else if (step && count_r < limit)
         count_nxt = count_r + W'(1); // Stop at selected wait
   end

   // Register only
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         count_r <= '0;
      else
         count_r <= count_nxt;
   end

   assign count = count_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_clear_zero;
      @(posedge clock) disable iff (!arst_n)
      clear |=> count_r == '0;
   endproperty
   a_clear_zero: assert property (p_clear_zero)
      else $error("settle count not cleared");

   property p_cap;
      @(posedge clock) disable iff (!arst_n)
      (!clear && step && count_r >= limit) |=> $stable(count_r);
   endproperty
   a_cap: assert property (p_cap)
      else $error("settle count passed selected wait");

endmodule

// ===== src/standby_stab_wait_control.sv
// Standby controller: halt and stop states, crystal settling wait,
// wait-select and settling status registers.
// Assumes pulses from the core on this clock; crystal signals async.
`timescale 1ns/1ps

module standby_stab_wait_control
   import standby_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire reg_req_s reg_req,
   output logic [7:0] rdata,
   input wire clk_src_e cpu_src,
   input wire logic halt_exec,
   input wire logic stop_exec,
   input wire logic irq_pending,
   input wire logic crystal_stop_ctrl,
   input wire osc_run_s osc_req,
   input wire logic xtal_started_pin,
   input wire logic xtal_tick_pin,
   output logic cpu_clk_en,
   output logic proc_hold,
   output logic halt_active,
   output logic stop_active,
   output logic retain_state,
   output osc_run_s osc_run
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [1:0] sync1_r; // First stage, read only by second
   logic [1:0] sync2_r; // Second stage: started, tick
   logic tick_d_r; // Tick history for edge detect
   pwr_state_e state_r, state_nxt; // Power state
   logic [2:0] wait_sel_r, wait_sel_nxt; // Wait code
   logic [NUM_THRESH-1:0] stat_r, stat_nxt; // Settling status
   logic [7:0] rdata_r, rdata_nxt; // Read data
   logic cpu_clk_en_r, cpu_clk_en_nxt; // Core clock enable
   logic proc_hold_r, proc_hold_nxt; // Held after stop exit
   logic halt_r, halt_nxt; // Halt flag
   logic stop_r, stop_nxt; // Stop flag
   logic retain_r, retain_nxt; // Freeze memory and latches
   osc_run_s osc_r, osc_nxt; // Oscillator run states
   logic [CNT_W-1:0] count; // Settled periods
   logic [CNT_W-1:0] limit; // Selected wait in periods
   logic started; // Crystal oscillating
   logic step; // One crystal period seen
   logic stop_go; // Stop taken this cycle
   logic cnt_clear; // Restart settling
   logic main_src; // Core on a main clock

   // ----------------------------------------------------------------
   // Crystal input synchronisers
   // ----------------------------------------------------------------
   // Pins are async to the core clock; two stages before use
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync1_r <= 2'h0;
         sync2_r <= 2'h0;
         tick_d_r <= 1'b0;
      end
      else
      begin
         sync1_r <= {xtal_tick_pin, xtal_started_pin};
         sync2_r <= sync1_r;
         tick_d_r <= sync2_r[1];
      end
   end

   assign started = sync2_r[0];
   // Periods count only once oscillation has begun
   assign step = started && sync2_r[1] && !tick_d_r;
   assign main_src = cpu_src != SRC_SUBSYS;
   // Stop is only possible from a main clock
   assign stop_go = state_r == ST_RUN && stop_exec && main_src;
   // Stop or the crystal stop control restarts settling
   assign cnt_clear = stop_go || crystal_stop_ctrl;
   assign limit = wait_limit(wait_sel_r);

   // ----------------------------------------------------------------
   // Settling counter
   // ----------------------------------------------------------------
   settle_counter #(.W(CNT_W)) u_count
   (
      .clock(clock),
      .arst_n(arst_n),
      .clear(cnt_clear),
      .step(step && state_r != ST_STOP),
      .limit(limit),
      .count(count)
   );

   // ----------------------------------------------------------------
   // Registers and status
   // ----------------------------------------------------------------
   // Byte-wide port; reads answer one cycle after the strobe
   always_comb
   begin
      wait_sel_nxt = wait_sel_r;
      if (reg_req.wr && reg_req.addr == ADDR_WAIT_SEL)
         wait_sel_nxt = reg_req.wdata[WAIT_CODE_W-1:0];
      // Bits accumulate; a hardware clear restarts them
      stat_nxt = cnt_clear ? STAT_RESET : stat_r | stat_of(count,
         wait_sel_r);
      rdata_nxt = 8'h00; // Unmapped and idle read zero
      if (reg_req.rd && reg_req.addr == ADDR_WAIT_SEL)
         rdata_nxt = {5'h00, wait_sel_r}; // Upper bits zero
      else if (reg_req.rd && reg_req.addr == ADDR_SETTLE_STAT)
         rdata_nxt = {3'h0, stat_r};
   end

   // Register only; reset loads longest wait
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wait_sel_r <= WAIT_SEL_RESET;
         stat_r <= STAT_RESET;
         rdata_r <= 8'h00;
      end
      else
      begin
         wait_sel_r <= wait_sel_nxt;
         stat_r <= stat_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Power state machine and clock control
   // ----------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN:
         begin
            if (stop_go)
               state_nxt = ST_STOP;
            else if (halt_exec)
               state_nxt = ST_HALT; // Any source may halt
         end
         ST_HALT:
         begin
            if (irq_pending)
               state_nxt = ST_RUN; // Interrupt resumes
         end
         ST_STOP:
         begin
            // Crystal-clocked core must wait for settling
            if (irq_pending)
               state_nxt = cpu_src == SRC_CRYSTAL ? ST_WAIT : ST_RUN;
         end
         ST_WAIT:
         begin
            if (count >= limit)
               state_nxt = ST_RUN;
         end
         default:
            state_nxt = ST_RUN;
      endcase
      // Core clock runs only in the run state
      cpu_clk_en_nxt = state_nxt == ST_RUN;
      proc_hold_nxt = state_nxt == ST_WAIT;
      halt_nxt = state_nxt == ST_HALT;
      stop_nxt = state_nxt == ST_STOP;
      // Memory and port latches frozen while idle
      retain_nxt = state_nxt != ST_RUN;
      // Oscillators other than the core's source follow software while running
      osc_nxt = osc_r;
      case (state_nxt)
         ST_RUN:
         begin
            osc_nxt = osc_req;
            osc_nxt.crystal = osc_req.crystal || cpu_src == SRC_CRYSTAL;
            osc_nxt.fast_int = osc_req.fast_int ||
               cpu_src == SRC_FAST_INT;
         end
         ST_HALT:
         begin
            // Others keep prior state
            if (main_src)
               osc_nxt.fast_int = 1'b1; // Cannot stop
            if (cpu_src == SRC_CRYSTAL)
               osc_nxt.crystal = 1'b1; // Core source runs
         end
         ST_STOP:
         begin
            osc_nxt.fast_int = 1'b0; // Main oscillators stop
            osc_nxt.crystal = 1'b0;
         end
         ST_WAIT:
         begin
            osc_nxt.crystal = 1'b1; // Needed for the settling count
            osc_nxt.fast_int = 1'b1;
         end
         default:
            osc_nxt = osc_r;
      endcase
      // External clock inputs are never gated here; they run or stop
      // purely with the applied signal
   end

   // Register only; reset leaves core running
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r <= ST_RUN;
         cpu_clk_en_r <= 1'b1;
         proc_hold_r <= 1'b0;
         halt_r <= 1'b0;
         stop_r <= 1'b0;
         retain_r <= 1'b0;
         osc_r <= 4'h0;
      end
      else
      begin
         state_r <= state_nxt;
         cpu_clk_en_r <= cpu_clk_en_nxt;
         proc_hold_r <= proc_hold_nxt;
         halt_r <= halt_nxt;
         stop_r <= stop_nxt;
         retain_r <= retain_nxt;
         osc_r <= osc_nxt;
      end
   end

   assign rdata = rdata_r;
   assign cpu_clk_en = cpu_clk_en_r;
   assign proc_hold = proc_hold_r;
   assign halt_active = halt_r;
   assign stop_active = stop_r;
   assign retain_state = retain_r;
   assign osc_run = osc_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   sequence s_crystal_exit;
      state_r == ST_STOP && irq_pending && cpu_src == SRC_CRYSTAL;
   endsequence
   sequence s_held;
      proc_hold_r && !cpu_clk_en_r;
   endsequence

   property p_hold_after_stop;
      s_crystal_exit |=> s_held;
   endproperty
   a_hold_after_stop: assert property (p_hold_after_stop)
      else $error("core not held after crystal stop exit");

   property p_hold_until_settled;
      (state_r == ST_WAIT && count < limit) |=> s_held;
   endproperty
   a_hold_until_settled: assert property (p_hold_until_settled)
      else $error("core released before settling");

   property p_upper_zero;
      reg_req.rd && reg_req.addr == ADDR_WAIT_SEL |=>
         rdata_r[7:3] == 5'h00 && rdata_r[2:0] == $past(wait_sel_r);
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("wait select upper bits not zero");

   property p_capped_status;
      (stat_r & ~stat_of(limit, wait_sel_r)) == 0;
   endproperty
   a_capped_status: assert property (p_capped_status)
      else $error("status bit beyond selected wait");

   property p_sticky;
      !cnt_clear |=> (stat_r & $past(stat_r)) == $past(stat_r);
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("settling status bit dropped");

   property p_stop_clears;
      cnt_clear |=> stat_r == STAT_RESET;
   endproperty
   a_stop_clears: assert property (p_stop_clears)
      else $error("status not cleared");

   property p_no_osc_no_count;
      (!started && !cnt_clear) |=> $stable(count);
   endproperty
   a_no_osc_no_count: assert property (p_no_osc_no_count)
      else $error("counted before oscillation");

   property p_halt_entry;
      (state_r == ST_RUN && halt_exec && !stop_go) |=>
         halt_r && !cpu_clk_en_r;
   endproperty
   a_halt_entry: assert property (p_halt_entry)
      else $error("halt did not gate core clock");

   property p_halt_exit;
      (state_r == ST_HALT && irq_pending) |=> cpu_clk_en_r && !halt_r;
   endproperty
   a_halt_exit: assert property (p_halt_exit)
      else $error("interrupt did not end halt");

   property p_halt_fast_runs;
      (halt_r && main_src) |-> osc_r.fast_int;
   endproperty
   a_halt_fast_runs: assert property (p_halt_fast_runs)
      else $error("fast oscillator stopped in halt");

   property p_halt_retain;
      (halt_r && $past(halt_r)) |->
         $stable(osc_r.subsys) && $stable(osc_r.slow_int);
   endproperty
   a_halt_retain: assert property (p_halt_retain)
      else $error("oscillator state changed in halt");

endmodule

// ===== testbench/standby_stab_wait_control_tb.sv
// Self-checking bench for the standby controller: registers, stop
// exit settling wait, halt entry and exit, status clearing.
// Assumes the package constants and a crystal tick of 4 core cycles.
`timescale 1ns/1ps

module standby_stab_wait_control_tb;
   import standby_pkg::*;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clock;
   logic arst_n;
   reg_req_s reg_req;
   logic [7:0] rdata;
   clk_src_e cpu_src;
   logic halt_exec;
   logic stop_exec;
   logic irq_pending;
   logic crystal_stop_ctrl;
   osc_run_s osc_req;
   logic xtal_started_pin;
   logic xtal_tick_pin;
   logic cpu_clk_en;
   logic proc_hold;
   logic halt_active;
   logic stop_active;
   logic retain_state;
   osc_run_s osc_run;
   logic tick_on; // Crystal running
   logic [1:0] tick_div; // Tick period, slow enough for the sync
   int mismatches;
   int total_checks;

   standby_stab_wait_control u_standby_stab_wait_control (
      .clock(clock), .arst_n(arst_n), .reg_req(reg_req),
      .rdata(rdata), .cpu_src(cpu_src), .halt_exec(halt_exec),
      .stop_exec(stop_exec), .irq_pending(irq_pending),
      .crystal_stop_ctrl(crystal_stop_ctrl), .osc_req(osc_req),
      .xtal_started_pin(xtal_started_pin),
      .xtal_tick_pin(xtal_tick_pin), .cpu_clk_en(cpu_clk_en),
      .proc_hold(proc_hold), .halt_active(halt_active),
      .stop_active(stop_active), .retain_state(retain_state),
      .osc_run(osc_run)
   );

   // ----------------------------------------------------------------
   // Clock and crystal tick
   // ----------------------------------------------------------------
   // 200 MHz core clock
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // One crystal period per four core cycles
   initial
   begin
      tick_div = 2'h0;
      forever
      begin
         @(posedge clock);
         #1;
         tick_div = tick_on ? tick_div + 2'h1 : 2'h0;
      end
   end
   assign xtal_tick_pin = tick_div[1];

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Inputs always move 1 ns after the edge
   task automatic step(input int n);
      repeat (n)
      begin
         @(posedge clock);
         #1;
      end
   endtask

   task automatic chk1(input string what, input logic e, input logic g);
      total_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("wrong value %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic chk8(input string what, input logic [7:0] e,
      input logic [7:0] g);
      total_checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask

   // Whole-byte write, one strobe cycle, then a free cycle so that a
   // following strobe never lands in the same time step
   task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
      reg_req.wr = 1'b1; // Byte writes only
      reg_req.addr = a;
      reg_req.wdata = d;
      step(1);
      reg_req.wr = 1'b0;
      step(1);
   endtask

   // Read strobe; data taken while it stands, then a free cycle
   task automatic reg_get(input logic [15:0] a, output logic [7:0] d);
      reg_req.rd = 1'b1;
      reg_req.addr = a;
      step(1);
      d = rdata;
      reg_req.rd = 1'b0;
      step(1);
   endtask

   // Read data stands in the cycle after the strobe
   task automatic reg_rd(input logic [15:0] a, input logic [7:0] e,
      input string what);
      logic [7:0] d;
      reg_get(a, d);
      chk8(what, e, d);
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Reset values, upper bits ignored, read-only and unmapped places
   task automatic test_regs;
      reg_rd(ADDR_WAIT_SEL, 8'h05, "wait select reset");
      reg_rd(ADDR_SETTLE_STAT, 8'h00, "status reset");
      reg_rd(16'hffa5, 8'h00, "unmapped read");
      reg_wr(ADDR_WAIT_SEL, 8'hfb);
      reg_rd(ADDR_WAIT_SEL, 8'h03, "code field only");
      reg_wr(ADDR_SETTLE_STAT, 8'hff);
      reg_rd(ADDR_SETTLE_STAT, 8'h00, "status read only");
      reg_wr(ADDR_WAIT_SEL, 8'h01);
      reg_rd(ADDR_WAIT_SEL, 8'h01, "shortest code");
      $display("test regs done");
   endtask

   // Stop on crystal, shortest wait; idle crystal must not count
   task automatic test_stop;
      int n;
      cpu_src = SRC_CRYSTAL;
      reg_wr(ADDR_WAIT_SEL, 8'h01);
      stop_exec = 1'b1;
      step(1);
      stop_exec = 1'b0;
      chk1("stop active", 1'b1, stop_active);
      chk1("core clock in stop", 1'b0, cpu_clk_en);
      tick_on = 1'b1;
      irq_pending = 1'b1;
      step(1);
      irq_pending = 1'b0;
      chk1("hold after wake", 1'b1, proc_hold);
      // Ticks without oscillation start: 2250 would pass the limit
      step(9000);
      chk1("hold before start", 1'b1, proc_hold);
      xtal_started_pin = 1'b1;
      n = 0;
      while (proc_hold === 1'b1 && n < 12000)
      begin
         step(1);
         n++;
      end
      if (n >= 12000)
      begin
         mismatches++;
         $display("wrong value settle wait expected end seen timeout");
         close_out();
      end
      // 2048 periods of 4 cycles, less sync slack
      chk1("wait length", 1'b1, n >= 8180);
      chk1("core clock back", 1'b1, cpu_clk_en);
      reg_rd(ADDR_SETTLE_STAT, 8'h10, "status capped");
      step(200);
      reg_rd(ADDR_SETTLE_STAT, 8'h10, "status sticky");
      tick_on = 1'b0;
      crystal_stop_ctrl = 1'b1;
      step(2);
      reg_rd(ADDR_SETTLE_STAT, 8'h00, "status cleared");
      crystal_stop_ctrl = 1'b0;
      xtal_started_pin = 1'b0;
      $display("test stop done");
   endtask

   // Stop on the fast oscillator: no hold, software polls the status
   task automatic test_fast_stop;
      logic [7:0] d;
      logic [7:0] first;
      int n;
      cpu_src = SRC_FAST_INT;
      // Wait chosen at least as long as the threshold polled
      reg_wr(ADDR_WAIT_SEL, 8'h02);
      stop_exec = 1'b1;
      step(1);
      stop_exec = 1'b0;
      chk1("fast stop active", 1'b1, stop_active);
      irq_pending = 1'b1;
      step(1);
      irq_pending = 1'b0;
      chk1("fast no hold", 1'b0, proc_hold);
      chk1("fast core clock", 1'b1, cpu_clk_en);
      tick_on = 1'b1;
      xtal_started_pin = 1'b1;
      first = 8'h00;
      d = 8'h00;
      n = 0;
      while (d !== 8'h18 && n < 20000)
      begin
         reg_get(ADDR_SETTLE_STAT, d);
         if (first == 8'h00)
            first = d;
         n++;
      end
      if (n >= 20000)
      begin
         mismatches++;
         $display("wrong value status poll expected 18 seen timeout");
         close_out();
      end
      chk8("first status bit", 8'h10, first);
      step(200);
      reg_rd(ADDR_SETTLE_STAT, 8'h18, "status up to wait");
      tick_on = 1'b0;
      xtal_started_pin = 1'b0;
      $display("test fast stop done");
   endtask

   // Second reset in mid-run: registers back to their reset values
   task automatic test_rereset;
      arst_n = 1'b0;
      step(2);
      chk1("core clock in reset", 1'b1, cpu_clk_en);
      chk1("no hold in reset", 1'b0, proc_hold);
      arst_n = 1'b1;
      reg_rd(ADDR_WAIT_SEL, 8'h05, "wait select rereset");
      reg_rd(ADDR_SETTLE_STAT, 8'h00, "status rereset");
      $display("test rereset done");
   endtask

   // Halt from each source: gating, oscillators, refused stop, wake
   task automatic test_halt;
      clk_src_e srcs [4];
      srcs = '{SRC_FAST_INT, SRC_CRYSTAL, SRC_EXT_MAIN, SRC_SUBSYS};
      osc_req = '{1'b0, 1'b0, 1'b1, 1'b1};
      foreach (srcs[i])
      begin
         cpu_src = srcs[i];
         step(2);
         halt_exec = 1'b1;
         step(1);
         halt_exec = 1'b0;
         chk1("halt active", 1'b1, halt_active);
         chk1("core clock gated", 1'b0, cpu_clk_en);
         chk1("retain", 1'b1, retain_state);
         chk1("fast osc", srcs[i] != SRC_SUBSYS,
            osc_run.fast_int);
         chk1("crystal osc", srcs[i] == SRC_CRYSTAL,
            osc_run.crystal);
         chk1("subsys osc", 1'b1, osc_run.subsys);
         chk1("slow osc", 1'b1, osc_run.slow_int);
         stop_exec = 1'b1;
         step(1);
         stop_exec = 1'b0;
         chk1("stop refused", 1'b0, stop_active);
         step(3);
         irq_pending = 1'b1;
         step(1);
         irq_pending = 1'b0;
         chk1("halt left", 1'b0, halt_active);
         chk1("core clock on", 1'b1, cpu_clk_en);
      end
      $display("test halt done");
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      mismatches = 0;
      total_checks = 0;
      arst_n = 1'b0;
      reg_req = '0;
      cpu_src = SRC_FAST_INT;
      halt_exec = 1'b0;
      stop_exec = 1'b0;
      irq_pending = 1'b0;
      crystal_stop_ctrl = 1'b0;
      osc_req = '{1'b1, 1'b1, 1'b0, 1'b1};
      xtal_started_pin = 1'b0;
      tick_on = 1'b0;
      step(8);
      arst_n = 1'b1;
      test_regs();
      test_stop();
      test_fast_stop();
      test_rereset();
      test_halt();
      close_out();
   end

endmodule
